// File: design/mts_pkg.sv
package mts_pkg;

	// trigger source selection
	typedef enum logic [1:0] {
		MTS_SRC_FREE,
		MTS_SRC_SINGLE,
		MTS_SRC_EXT,
		MTS_SRC_LEVEL
	} mts_src_e;

	// delay mode selection
	typedef enum logic [1:0] {
		MTS_DLY_AUTO,
		MTS_DLY_ZERO,
		MTS_DLY_MANUAL
	} mts_dly_e;

	// measurement function classes
	typedef enum logic [1:0] {
		MTS_FN_DC_VOLTAGE,
		MTS_FN_DC_CURRENT,
		MTS_FN_RESISTANCE,
		MTS_FN_OTHER
	} mts_fn_e;

	// apb request bundle
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} mts_apb_req_s;

	// apb register offsets
	localparam logic [11:0] MTS_OFF_CTRL   = 12'h000;
	localparam logic [11:0] MTS_OFF_COUNT  = 12'h004;
	localparam logic [11:0] MTS_OFF_DELAY  = 12'h008;
	localparam logic [11:0] MTS_OFF_LEVEL  = 12'h00C;
	localparam logic [11:0] MTS_OFF_ACTION = 12'h010;
	localparam logic [11:0] MTS_OFF_STATUS = 12'h014;
	localparam logic [11:0] MTS_OFF_HELD   = 12'h018;

	// control register field positions
	localparam int MTS_CTRL_SRC_LO  = 0;
	localparam int MTS_CTRL_DLY_LO  = 2;
	localparam int MTS_CTRL_FALL    = 4;
	localparam int MTS_CTRL_PULSE   = 5;
	localparam int MTS_CTRL_HOLD    = 6;
	localparam int MTS_CTRL_BAND_LO = 7;

	// action register bits (write one to fire)
	localparam int MTS_ACT_SINGLE = 0;
	localparam int MTS_ACT_RUNHOLD = 1;

	// status register bits
	localparam int MTS_ST_BUSY   = 0;
	localparam int MTS_ST_REMOTE = 1;
	localparam int MTS_ST_HOLD   = 2;

	// reset values
	localparam logic [15:0] MTS_COUNT_RST = 16'h0001;
	localparam logic [15:0] MTS_COUNT_MAX = 16'hC350;
	localparam logic [1:0]  MTS_BAND_RST  = 2'h1;
	localparam logic [31:0] MTS_UNMAPPED  = 32'h0000_0000;

	// timing: manual delay in milliseconds, clock rate
	localparam int          MTS_CLK_HZ       = 25_000_000;
	localparam int          MTS_DLY_MAX_MS   = 3_600_000;
	localparam int          MTS_CYC_PER_MS   = MTS_CLK_HZ / 1000;
	localparam int          MTS_PULSE_NS     = 40;
	localparam int          MTS_PULSE_CYC    = (MTS_PULSE_NS * 25 + 999) / 1000;
	localparam int          MTS_HOLD_HITS    = 3;

	// band divisors: shift of range giving 0.01,0.1,1,10 percent approx
	localparam logic [4:0] MTS_BAND_SH0 = 5'd13;
	localparam logic [4:0] MTS_BAND_SH1 = 5'd10;
	localparam logic [4:0] MTS_BAND_SH2 = 5'd7;
	localparam logic [4:0] MTS_BAND_SH3 = 5'd3;

endpackage : mts_pkg

// File: design/mts_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// - four trigger sources, free-running after reset
// - burst count 1 to 50000, default one
// - free-running starts readings back to back
// - single key event starts one burst
// - external edge of chosen polarity starts burst
// - level crossing triggers, dc and resistance only
// - slope selects edge for external and level
// - delay precedes every reading of burst
// - delay auto, zero, or manual 0-3600 s
// - enabled done output pulses low per reading
// - hold updates after three out-of-band readings
// - band 0.01/0.1/1/10 percent, default 0.1
// - run/hold event in free-running engages hold
// - single key event under remote returns local
module mts_sequencer #(
	parameter int DLY_CYC_PER_MS = mts_pkg::MTS_CYC_PER_MS,
	parameter int RW             = 24
) (
	input  wire logic               mclk,
	input  wire logic               rst_n,
	input  wire mts_pkg::mts_apb_req_s apb_req,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               ext_trig_in,
	input  wire logic               single_key,
	input  wire logic               runhold_key,
	input  wire logic               remote_mode,
	input  wire mts_pkg::mts_fn_e   meas_function,
	input  wire logic [RW-1:0]      input_level,
	input  wire logic [RW-1:0]      range_full,
	input  wire logic [15:0]        auto_delay_cyc,
	output logic                    reading_start,
	input  wire logic               reading_ready,
	input  wire logic [RW-1:0]      reading_value,
	output logic [RW-1:0]           display_value,
	output logic                    go_local,
	output logic                    measurement_done_output_n
);

	// refuse widths that the band shifts and the read mux cannot serve
	if (RW < 8 || RW > 32 || DLY_CYC_PER_MS < 1) begin : g_bad_param
		$error("mts_sequencer: unsupported parameters");
	end

	////////////////////////////////////////////////////////////////////////
	// register file
	mts_pkg::mts_src_e src_r;                   // trigger source
	mts_pkg::mts_dly_e dly_mode_r;              // delay mode
	logic              slope_fall_r;            // falling edge select
	logic              complete_pulse_enable_r; // done pulse enable
	logic              hold_en_r;               // reading hold enable
	logic [1:0]        band_r;                  // hold band select
	logic [15:0]       count_r;                 // burst count
	logic [21:0]       dly_ms_r;                // manual delay, ms
	logic [RW-1:0]     level_r;                 // trigger level
	logic              busy_r;                  // burst in progress
	logic              act_single;              // key or software single event
	logic              act_runhold;             // key or software run/hold event
	logic              wr_acc;                  // write access phase
	logic [11:0]       addr;                    // request address

	assign addr   = apb_req.paddr;
	assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
	// every access completes in one cycle, no error response exists
	assign pready  = 1'b1;  // zero wait states
	assign pslverr = 1'b0;

	// configuration writes
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			src_r                   <= mts_pkg::MTS_SRC_FREE;
			dly_mode_r              <= mts_pkg::MTS_DLY_AUTO;
			slope_fall_r            <= 1'b0;
			complete_pulse_enable_r <= 1'b0;
			hold_en_r               <= 1'b0;
			band_r                  <= mts_pkg::MTS_BAND_RST;
			count_r                 <= mts_pkg::MTS_COUNT_RST;
			dly_ms_r                <= '0;
			level_r                 <= '0;
		end else begin
			if (wr_acc && addr == mts_pkg::MTS_OFF_CTRL) begin
				src_r <= mts_pkg::mts_src_e'(
					apb_req.pwdata[mts_pkg::MTS_CTRL_SRC_LO +: 2]);
				if (apb_req.pwdata[mts_pkg::MTS_CTRL_DLY_LO +: 2] != 2'h3)
					dly_mode_r <= mts_pkg::mts_dly_e'(
						apb_req.pwdata[mts_pkg::MTS_CTRL_DLY_LO +: 2]);
				slope_fall_r <= apb_req.pwdata[mts_pkg::MTS_CTRL_FALL];
				complete_pulse_enable_r <=
					apb_req.pwdata[mts_pkg::MTS_CTRL_PULSE];
				hold_en_r <= apb_req.pwdata[mts_pkg::MTS_CTRL_HOLD];
				band_r <= apb_req.pwdata[mts_pkg::MTS_CTRL_BAND_LO +: 2];
			end else if (act_runhold && src_r == mts_pkg::MTS_SRC_FREE) begin
				hold_en_r <= 1'b1;
			end
			// out-of-range counts are refused, old value kept
			if (wr_acc && addr == mts_pkg::MTS_OFF_COUNT
				&& apb_req.pwdata[31:16] == 16'h0000
				&& apb_req.pwdata[15:0] != 16'h0000
				&& apb_req.pwdata[15:0] <= mts_pkg::MTS_COUNT_MAX)
				count_r <= apb_req.pwdata[15:0];
			if (wr_acc && addr == mts_pkg::MTS_OFF_DELAY
				&& apb_req.pwdata <= 32'(mts_pkg::MTS_DLY_MAX_MS))
				dly_ms_r <= apb_req.pwdata[21:0];
			if (wr_acc && addr == mts_pkg::MTS_OFF_LEVEL)
				level_r <= apb_req.pwdata[RW-1:0];
		end
	end

	// action strobes from software, or front-panel key pins
	assign act_single  = single_key | (wr_acc
		&& addr == mts_pkg::MTS_OFF_ACTION
		&& apb_req.pwdata[mts_pkg::MTS_ACT_SINGLE]);
	assign act_runhold = runhold_key | (wr_acc
		&& addr == mts_pkg::MTS_OFF_ACTION
		&& apb_req.pwdata[mts_pkg::MTS_ACT_RUNHOLD]);

	// read mux, registered data
	// captured in the setup phase so the word stands through access
	// and until the next read setup
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= '0;
		end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
			case (addr)
				mts_pkg::MTS_OFF_CTRL:   prdata <= 32'({band_r, hold_en_r,
					complete_pulse_enable_r, slope_fall_r, dly_mode_r, src_r});
				mts_pkg::MTS_OFF_COUNT:  prdata <= 32'(count_r);
				mts_pkg::MTS_OFF_DELAY:  prdata <= 32'(dly_ms_r);
				mts_pkg::MTS_OFF_LEVEL:  prdata <= 32'(level_r);
				mts_pkg::MTS_OFF_STATUS: prdata <= 32'({hold_en_r,
					remote_mode, busy_r});
				mts_pkg::MTS_OFF_HELD:   prdata <= 32'(display_value);
				default:                 prdata <= mts_pkg::MTS_UNMAPPED;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// trigger detection
	logic ext_q_r;        // previous external pin level
	logic above_q_r;      // previous level comparison
	logic above;          // input above level now
	logic ext_edge;       // selected edge on external pin
	logic lvl_edge;       // selected crossing of level
	logic lvl_allowed;    // function supports level trigger
	logic trig;           // accepted trigger event

	assign above = input_level > level_r;
	assign ext_edge = slope_fall_r ? (ext_q_r & ~ext_trig_in)
		: (~ext_q_r & ext_trig_in);
	assign lvl_edge = slope_fall_r ? (above_q_r & ~above)
		: (~above_q_r & above);
	assign lvl_allowed = meas_function != mts_pkg::MTS_FN_OTHER;

	// edge history
	// both histories reset low, so a level already above the threshold
	// after reset looks like a rising crossing on the first clock
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ext_q_r   <= 1'b0;
			above_q_r <= 1'b0;
		end else begin
			ext_q_r   <= ext_trig_in;
			above_q_r <= above;
		end
	end

	// source selection
	// free running re-arms from idle every cycle, so readings run back
	// to back, limited only by the delay and the conversion time
	always_comb begin
		case (src_r)
			mts_pkg::MTS_SRC_FREE:   trig = 1'b1;
			mts_pkg::MTS_SRC_SINGLE: trig = act_single;
			mts_pkg::MTS_SRC_EXT:    trig = ext_edge;
			mts_pkg::MTS_SRC_LEVEL:  trig = lvl_edge & lvl_allowed;
			default:                 trig = 1'b0;
		endcase
	end

	// single key under remote hands control back to local
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			go_local <= 1'b0;
		else
			go_local <= act_single & remote_mode;
	end

	////////////////////////////////////////////////////////////////////////
	// burst sequencer
	// idle waits for a trigger, delay counts down before every reading,
	// meas waits for the front end to report the reading
	typedef enum logic [1:0] {
		MTS_ST_IDLE,
		MTS_ST_DELAY,
		MTS_ST_MEAS
	} mts_seq_e;

	mts_seq_e    st_r;       // sequencer state
	logic [15:0] left_r;     // readings still to take
	logic [21:0] ms_r;       // delay milliseconds left
	logic [31:0] cyc_r;      // cycles left in current ms or auto delay
	logic        dly_done;   // delay expired this cycle
	logic        start_r;    // reading start strobe
	logic [31:0] dly_load_cyc; // initial cycle count of a delay
	logic [21:0] dly_load_ms;  // initial ms count of a delay

	// delay preload per reading: auto counts cycles only, manual counts
	// whole milliseconds, each refilled with a full ms of cycles on entry,
	// so long manual delays never need a counter wider than 32 bits
	always_comb begin
		case (dly_mode_r)
			mts_pkg::MTS_DLY_AUTO: begin
				dly_load_cyc = 32'(auto_delay_cyc);
				dly_load_ms  = '0;
			end
			mts_pkg::MTS_DLY_MANUAL: begin
				dly_load_cyc = '0;
				dly_load_ms  = dly_ms_r;
			end
			default: begin
				dly_load_cyc = '0;
				dly_load_ms  = '0;
			end
		endcase
	end

	// delay has run out once both counters are empty; a zero delay is
	// therefore done in the first delay cycle
	assign dly_done = cyc_r == 32'h0000_0000 && ms_r == 22'h000000;

	// state, counters and start strobe
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_r    <= MTS_ST_IDLE;
			left_r  <= '0;
			ms_r    <= '0;
			cyc_r   <= '0;
			start_r <= 1'b0;
			busy_r  <= 1'b0;
		end else begin
			start_r <= 1'b0;
			case (st_r)
				MTS_ST_IDLE: begin
					if (trig) begin
						st_r   <= MTS_ST_DELAY;
						left_r <= count_r;
						ms_r   <= dly_load_ms;
						cyc_r  <= dly_load_cyc;
						busy_r <= 1'b1;
					end
				end
				MTS_ST_DELAY: begin // triggers ignored here
					if (dly_done) begin
						st_r    <= MTS_ST_MEAS;
						start_r <= 1'b1;
					end else if (cyc_r != 32'h0000_0000) begin
						// drain the cycles of the current stretch
						cyc_r <= cyc_r - 32'h0000_0001;
					end else begin
						// open the next millisecond, this cycle counts
						ms_r  <= ms_r - 22'h000001;
						cyc_r <= 32'(DLY_CYC_PER_MS - 1);
					end
				end
				MTS_ST_MEAS: begin
					if (reading_ready) begin
						if (left_r == 16'h0001) begin
							st_r   <= MTS_ST_IDLE;
							busy_r <= 1'b0;
						end else begin
							st_r  <= MTS_ST_DELAY;
							ms_r  <= dly_load_ms;
							cyc_r <= dly_load_cyc;
						end
						left_r <= left_r - 16'h0001;
					end
				end
				default: st_r <= MTS_ST_IDLE;
			endcase
		end
	end

	assign reading_start = start_r;

	// done pulse, one cycle low per finished reading
	// readings never finish back to back, so each pulse is separate
	// from the next one by at least one high cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			measurement_done_output_n <= 1'b1;
		else
			measurement_done_output_n <= ~(st_r == MTS_ST_MEAS
				&& reading_ready && complete_pulse_enable_r);
	end

	////////////////////////////////////////////////////////////////////////
	// reading hold filter
	// band half-widths are shift approximations of the full range
	logic [RW-1:0] diff;     // distance from held value
	logic [RW-1:0] band;     // band half-width
	logic [1:0]    hits_r;   // consecutive out-of-band count
	logic          outside;  // reading outside band

	always_comb begin
		case (band_r)
			2'h0:    band = range_full >> mts_pkg::MTS_BAND_SH0;
			2'h1:    band = range_full >> mts_pkg::MTS_BAND_SH1;
			2'h2:    band = range_full >> mts_pkg::MTS_BAND_SH2;
			default: band = range_full >> mts_pkg::MTS_BAND_SH3;
		endcase
	end

	assign diff = reading_value > display_value
		? reading_value - display_value : display_value - reading_value;
	assign outside = diff > band;

	// display update
	// with hold off every reading is shown; with hold on only a run of
	// three out-of-band readings replaces the held value
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			display_value <= '0;
			hits_r        <= '0;
		end else if (st_r == MTS_ST_MEAS && reading_ready) begin
			if (!hold_en_r) begin
				display_value <= reading_value;
				hits_r        <= '0;
			end else if (!outside) begin
				hits_r <= '0;
			end else if (hits_r == 2'(mts_pkg::MTS_HOLD_HITS - 1)) begin
				display_value <= reading_value;
				hits_r        <= '0;
			end else begin
				hits_r <= hits_r + 2'h1;
			end
		end
	end

endmodule : mts_sequencer

// File: bench/mts_sequencer_assertions.sv
`timescale 1ns/1ps
module mts_sequencer_assertions #(
	parameter int DLY_CYC_PER_MS = 2,
	parameter int RW             = 24
) (
	input wire logic                  mclk,
	input wire logic                  rst_n,
	input wire mts_pkg::mts_apb_req_s apb_req,
	input wire logic                  single_key,
	input wire logic                  remote_mode,
	input wire logic                  reading_start,
	input wire logic                  reading_ready,
	input wire logic [RW-1:0]         display_value,
	input wire logic                  go_local,
	input wire logic                  measurement_done_output_n
);
	logic pulse_en_r; // shadow of pulse enable
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////
	// follow control writes at the access edge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			pulse_en_r <= 1'b0;
		else if (apb_req.psel && apb_req.penable && apb_req.pwrite &&
			apb_req.paddr == mts_pkg::MTS_OFF_CTRL)
			pulse_en_r <= apb_req.pwdata[mts_pkg::MTS_CTRL_PULSE];
	end
	////////////////////////////////////////////////////////////////////
	a_free_start: assert property (
		$rose(rst_n) |-> ##[1:40] reading_start)
		else $error("no reading after reset");
	a_start_gap: assert property (
		reading_start |=> !reading_start [*2])
		else $error("reading start too soon");
	a_done_cause: assert property (
		$fell(measurement_done_output_n) |->
		$past(reading_ready) && $past(pulse_en_r))
		else $error("done pulse without cause");
	a_done_when_on: assert property (
		reading_ready && pulse_en_r |=> !measurement_done_output_n)
		else $error("done pulse missing");
	a_done_single: assert property (
		$fell(measurement_done_output_n) |=> measurement_done_output_n)
		else $error("done pulse too long");
	a_local_return: assert property (
		single_key && remote_mode |=> go_local)
		else $error("no return to local");
	a_local_cause: assert property (
		$rose(go_local) |-> $past(remote_mode))
		else $error("local pulse while local");
	a_display_cause: assert property (
		!$stable(display_value) |-> $past(reading_ready))
		else $error("display moved without reading");
endmodule : mts_sequencer_assertions

bind mts_sequencer mts_sequencer_assertions #(
	.DLY_CYC_PER_MS(DLY_CYC_PER_MS), .RW(RW)) u_chk (
	.mclk(mclk), .rst_n(rst_n), .apb_req(apb_req),
	.single_key(single_key), .remote_mode(remote_mode),
	.reading_start(reading_start), .reading_ready(reading_ready),
	.display_value(display_value), .go_local(go_local),
	.measurement_done_output_n(measurement_done_output_n));

// File: bench/mts_front_end.sv
`timescale 1ns/1ps
module mts_front_end #(
	parameter int RW = 24
) (
	input  wire logic          mclk,
	input  wire logic          rst_n,
	input  wire logic          reading_start,
	input  wire logic [7:0]    lat,
	input  wire logic [RW-1:0] value,
	output logic               reading_ready,
	output logic [RW-1:0]      reading_value
);
	logic [7:0]    wait_r; // cycles left to answer
	logic [RW-1:0] last_r; // value handed over
	////////////////////////////////////////////////////////////////////
	// conversion timer, one ready per start
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wait_r        <= 8'h00;
			last_r        <= '0;
			reading_ready <= 1'b0;
		end else begin
			reading_ready <= (wait_r == 8'h01);
			if (wait_r == 8'h01)
				last_r <= value;
			if (reading_start)
				wait_r <= lat;
			else if (wait_r != 8'h00)
				wait_r <= wait_r - 8'h01;
		end
	end
	// data valid only beside ready
	assign reading_value = reading_ready ? last_r : ~last_r;
endmodule : mts_front_end

// File: bench/mts_sequencer_tb.sv
`timescale 1ns/1ps
module mts_sequencer_tb;
	typedef struct packed {
		logic [11:0] a; // offset
		logic [31:0] w; // written
		logic [31:0] x; // read back
	} mts_row_s;
	mts_pkg::mts_apb_req_s req;
	mts_pkg::mts_fn_e      fn;
	logic                  mclk, rst_n, ext, skey, rkey, remote;
	logic                  pready, pslverr, rstart, rready, golocal, done_n;
	logic [31:0]           prdata, q;
	logic [23:0]           lvl, disp, rval, pv;
	logic [7:0]            lat;
	int                    err_total, compares, cyc, n_start, n_done;
	int                    n_loc, s0, d0, last, gmin, gmax;
	// register rows, refused writes keep the old value
	mts_row_s rows[9] = '{
		'{12'h004, 32'h0, 32'h1}, '{12'h004, 32'hC351, 32'h1},
		'{12'h004, 32'hC350, 32'hC350}, '{12'h004, 32'h3, 32'h3},
		'{12'h008, 32'h36EE80, 32'h36EE80},
		'{12'h008, 32'h36EE81, 32'h36EE80},
		'{12'h008, 32'h5, 32'h5}, '{12'h01C, 32'h5, 32'h0},
		'{12'h00C, 32'h64, 32'h64}};
	logic [31:0] dm[3] = '{32'h4, 32'h0, 32'h8}; // zero, auto, manual
	int          dd[3] = '{0, 4, 10};             // delay cycles
	logic [31:0] hc[6] = '{32'h84, 32'hC4, 32'hC4, 32'h1C4, 32'h44, 32'h144};
	logic [31:0] hv[6] = '{32'h3E8, 32'h5DC, 32'hBB8, 32'hC350, 32'hC80,
		32'h2328};
	logic [31:0] hx[6] = '{32'h3E8, 32'h3E8, 32'hBB8, 32'hBB8, 32'hC80,
		32'hC80};
	always #20 mclk = ~mclk;
	mts_sequencer #(.DLY_CYC_PER_MS(2), .RW(24)) u_dut (
		.mclk(mclk), .rst_n(rst_n), .apb_req(req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_trig_in(ext),
		.single_key(skey), .runhold_key(rkey), .remote_mode(remote),
		.meas_function(fn), .input_level(lvl), .range_full(24'h10_0000),
		.auto_delay_cyc(16'h0004), .reading_start(rstart),
		.reading_ready(rready), .reading_value(rval), .display_value(disp),
		.go_local(golocal), .measurement_done_output_n(done_n));
	mts_front_end #(.RW(24)) u_fe (.mclk(mclk), .rst_n(rst_n),
		.reading_start(rstart), .lat(lat), .value(pv),
		.reading_ready(rready), .reading_value(rval));
	////////////////////////////////////////////////////////////////////
	// event counters, gap tracking, timeout
	always @(posedge mclk) begin
		cyc = cyc + 1;
		n_start = n_start + rstart;
		n_done = n_done + !done_n;
		n_loc = n_loc + golocal;
		if (rstart) begin
			gmin = (cyc - last < gmin) ? cyc - last : gmin;
			gmax = (cyc - last > gmax) ? cyc - last : gmax;
		end
		if (skey || rready)
			last = cyc;
		if (cyc == 10000) begin
			err_total++;
			wrap_up();
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	// one apb transfer, held until pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge mclk);
		req.penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1)
			@(posedge mclk);
		q = prdata;
		req <= '0;
	endtask : apb
	task key;
		skey <= 1'b1;
		@(posedge mclk);
		skey <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask : key
	// settle, then readings and done pulses since last call
	task ex(input string nm, input int es, input int ed);
		repeat (150) @(posedge mclk);
		chk(nm, es, n_start - s0);
		chk(nm, ed, n_done - d0);
		s0 = n_start;
		d0 = n_done;
	endtask : ex
	task wrap_up;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////
	initial begin
		{mclk, rst_n, ext, skey, rkey, remote} = 6'h00;
		{err_total, compares, cyc, n_start, n_done, n_loc} = '0;
		req = '0;
		lvl = 24'h000032;
		pv = 24'h0003E8;
		lat = 8'h02;
		fn = mts_pkg::MTS_FN_DC_VOLTAGE;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (60) @(posedge mclk);
		chk("free run", 1, n_start > 3);
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl reset", 32'h80, q);
		apb(1'b0, 12'h004, 32'h0);
		chk("count reset", 32'h1, q);
		chk("slave error", 32'h0, {31'h0, pslverr});
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].w);
			apb(1'b0, rows[i].a, 32'h0);
			chk("register", rows[i].x, q);
		end
		apb(1'b1, 12'h000, 32'hA5);
		repeat (40) @(posedge mclk);
		s0 = n_start;
		d0 = n_done;
		key();
		key(); // lands mid-burst
		ex("single", 3, 3);
		apb(1'b1, 12'h010, 32'h1);
		ex("action", 3, 3);
		apb(1'b1, 12'h000, 32'h85);
		key();
		ex("no pulse", 3, 0);
		lat <= 8'h06;
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, 12'h000, 32'hA1 | dm[i]);
			gmin = 999;
			gmax = 0;
			key();
			ex("delay", 3, 3);
			chk("gap low", 1, gmin >= dd[i]);
			chk("gap high", 1, gmax <= dd[i] + 6);
		end
		lat <= 8'h02;
		for (int s = 0; s < 2; s++) begin
			apb(1'b1, 12'h000, 32'hA6 | (s << 4));
			ext <= 1'b1;
			ex("ext up", s ? 0 : 3, s ? 0 : 3);
			ext <= 1'b0;
			ex("ext down", s ? 3 : 0, s ? 3 : 0);
		end
		for (int i = 0; i < 5; i++) begin
			fn <= mts_pkg::mts_fn_e'(i % 4);
			apb(1'b1, 12'h000, 32'hA7 | ((i / 4) << 4));
			lvl <= 24'h000096;
			ex("level up", i < 3 ? 3 : 0, i < 3 ? 3 : 0);
			lvl <= 24'h000032;
			ex("level down", i > 3 ? 3 : 0, i > 3 ? 3 : 0);
		end
		remote <= 1'b1;
		key();
		chk("to local", 1, n_loc);
		remote <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, 12'h000, hc[i]);
			pv <= hv[i][23:0];
			repeat (80) @(posedge mclk);
			chk("display", hx[i], {8'h00, disp});
		end
		apb(1'b1, 12'h000, 32'h84);
		rkey <= 1'b1;
		@(posedge mclk);
		rkey <= 1'b0;
		apb(1'b0, 12'h014, 32'h0);
		chk("hold set", 1, q[2]);
		wrap_up();
	end
endmodule : mts_sequencer_tb
